// [logic/pchtp_port.sv]
`timescale 1ns/1ps

// Power-of-two depth only: pointers wrap by overflow
module pchtp_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Fill side
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  // Drain side
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wrPtr;
    logic [AW-1:0]           rdPtr;
    logic [AW:0]             count;
  } pchtp_fifo_state_t;

  pchtp_fifo_state_t st_reg;
  pchtp_fifo_state_t st_next;
  logic              push;
  logic              pop;

  assign inReady  = st_reg.count != (AW+1)'(DEPTH);
  assign outValid = st_reg.count != '0;
  assign outData  = st_reg.mem[st_reg.rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outReady && outValid;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wrPtr] = inData;
      st_next.wrPtr             = st_reg.wrPtr + 1'b1;
    end
    if (pop) begin
      st_next.rdPtr = st_reg.rdPtr + 1'b1;
    end
    st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule // pchtp_fifo

// Operation
// - No host interrupt while DMA active
// - XT DMA single or demand when enabled
// - AT PIO select blocks all DMA
// - AT ungated DMA enabled whenever PIO not selected
// - AT gated DMA needs fixed-disk bit
// - Single mode drops request on acknowledge
// - Demand mode holds request unless buffer limited
// - Wait states only in programmed I/O
// - Programmed wait count on every I/O
// - Automatic waits when buffer not ready
// - Automatic waits follow the programmed count
// - Write-type commands auto-start host data intake
// - Auto-start interrupts microcontroller when enabled
// - Auto-start loads fixed stop pointer
// - Auto-start locks formatter and register access
// - Unlock write restores access and formatter
// - Long command runs past stop pointer
// - Drain words, then ECC bytes in byte mode
// - Master/slave selection by drive bits
// - All accept writes; only selected execute, except diagnostic, which all execute
module pchtp_port (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // Configuration
  input  wire pchtp_pkg::pchtp_cfg_t cfg,
  // Microcontroller side
  input  wire logic                  xferStart,
  input  wire logic                  xferDirRead,
  input  wire logic                  stopLoad,
  input  wire logic [15:0]           stopValue,
  input  wire logic                  unlockWrite,
  input  wire logic                  hostIrqReq,
  output logic                       mcuIrq,
  output logic                       formatterConnected,
  output logic                       mcuRegWriteAllow,
  output logic                       mcuBufAccessAllow,
  // Host pins
  input  wire pchtp_pkg::pchtp_host_in_t hostIn,
  output logic                       hostDreq,
  output logic                       hostIochrdyOe,
  output logic [15:0]                hostRdData,
  output logic                       hostDataOe,
  output logic                       hostIrq,
  // Status
  output logic [15:0]                hostBufferPointer,
  output logic [15:0]                stopPointer,
  output logic                       xferDone,
  output logic                       hostByteMode,
  output logic [7:0]                 cmdByte,
  output logic                       execCommand,
  output logic                       reportBoth,
  // Buffer manager side
  output logic                       bufWrValid,
  output logic [15:0]                bufWrData,
  input  wire logic                  bufWrReady,
  input  wire logic                  bufRdValid,
  input  wire logic [15:0]           bufRdData,
  output logic                       bufRdReady
);
  import pchtp_pkg::*;

  typedef struct packed {
    pchtp_host_in_t sync1;
    pchtp_host_in_t sync2;
    logic           iorPrev;
    logic           iowPrev;
    pchtp_xfer_t    xfer;
    logic           dirRead;
    logic           longCmd;
    logic           locked;
    logic           stopArmed;
    logic [15:0]    hostPtr;
    logic [15:0]    stopPtr;
    logic [3:0]     eccLeft;
    logic [1:0]     waitLeft;
    logic           popped;
    logic           dreq;
    logic           waitOe;
    logic           dataOe;
    logic [15:0]    rdData;
    logic           hostIrq;
    logic           mcuIrq;
    logic           xferDone;
    logic           byteMode;
    logic           execCmd;
    logic           reportBoth;
    logic [7:0]     cmdByte;
  } pchtp_state_t;

  localparam pchtp_state_t STATE_RESET = '{sync1: HOST_IDLE, sync2: HOST_IDLE, iorPrev: 1'b1,
                                           iowPrev: 1'b1, xfer: XIDLE, default: '0};

  pchtp_state_t   st_reg;
  pchtp_state_t   st_next;
  pchtp_host_in_t h;
  logic           iorEnd;
  logic           iowEnd;
  logic           strobeStart;
  logic           strobeActive;
  logic           pioCycle;
  logic           selected;
  logic           diagCmd;
  logic           dmaOk;
  logic           xferActive;
  logic           xferCycle;
  logic           devReady;
  logic           hostPush;
  logic           hostPop;
  logic           cmdWrite;
  logic           autoCmd;
  logic           stopHit;
  logic           okReq;
  logic           fifoInValid;
  logic [15:0]    fifoInData;
  logic           fifoInReady;
  logic           fifoOutValid;
  logic [15:0]    fifoOutData;
  logic           fifoOutReady;

  // Only the second synchroniser stage is looked at
  assign h            = st_reg.sync2;
  assign iorEnd       = h.ior_n && !st_reg.iorPrev;
  assign iowEnd       = h.iow_n && !st_reg.iowPrev;
  assign strobeStart  = (!h.ior_n && st_reg.iorPrev) || (!h.iow_n && st_reg.iowPrev);
  assign strobeActive = !h.ior_n || !h.iow_n;
  assign pioCycle     = strobeActive && h.ioSel && h.dack_n;
  assign selected     = !cfg.masterSlaveEn ||
                        (cfg.atMode ? (h.atDriveSel == cfg.slaveSelect)
                                    : (h.xtSlaveBit == cfg.slaveSelect));
  assign diagCmd      = h.wrData[7:0] == CMD_DIAG;
  assign dmaOk        = selected && (cfg.atMode
                        ? (!cfg.pioSelect && (!cfg.hostDmaGateEnable || cfg.fixedDiskDmaBit))
                        : cfg.xtDmaEnable);
  assign xferActive   = st_reg.xfer != XIDLE;
  assign xferCycle    = xferActive && (h.dack_n ? (h.dataSel && selected) : dmaOk);
  assign devReady     = st_reg.dirRead ? (fifoOutValid || st_reg.popped) : fifoInReady;
  assign hostPush     = !st_reg.dirRead && iowEnd && xferCycle;
  assign hostPop      = st_reg.dirRead && !h.ior_n && !st_reg.popped && xferCycle && fifoOutValid;
  assign cmdWrite     = iowEnd && h.cmdSel;
  assign autoCmd      = cmdWrite && selected && isAutoCmd(h.wrData[7:0]);
  // Word mode hits on the word that holds the stop byte, so an odd stop value still ends
  assign stopHit      = st_reg.stopArmed && (st_reg.hostPtr[15:1] == st_reg.stopPtr[15:1]);
  assign okReq        = (st_reg.xfer == XRUN || st_reg.xfer == XECC) && dmaOk && devReady;

  // Read direction fills from the buffer, write direction from the host
  assign fifoInValid  = st_reg.dirRead ? (bufRdValid && st_reg.xfer != XDRAIN) : hostPush;
  assign fifoInData   = st_reg.dirRead ? bufRdData : h.wrData;
  assign fifoOutReady = st_reg.dirRead ? hostPop : bufWrReady;
  assign bufRdReady   = st_reg.dirRead && fifoInReady && st_reg.xfer != XDRAIN;
  assign bufWrValid   = !st_reg.dirRead && fifoOutValid;
  assign bufWrData    = fifoOutData;

  pchtp_fifo #(
    .W     (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rstn     (rstn),
    .inValid  (fifoInValid),
    .inData   (fifoInData),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (fifoOutReady)
  );

  always_comb begin
    logic       done;
    logic [1:0] wl;
    done    = 1'b0;
    wl      = st_reg.waitLeft;
    st_next = st_reg;
    st_next.sync1   = hostIn;
    st_next.sync2   = st_reg.sync1;
    st_next.iorPrev = h.ior_n;
    st_next.iowPrev = h.iow_n;
    st_next.execCmd = 1'b0;
    st_next.mcuIrq  = 1'b0;

    // Host read data is taken from the FIFO once per strobe
    if (hostPop) begin
      st_next.popped = 1'b1;
      st_next.rdData = fifoOutData;
    end
    if (iorEnd) begin
      st_next.popped = 1'b0;
    end
    st_next.dataOe = !h.ior_n && xferCycle && st_reg.dirRead;

    // A write into a full FIFO is lost and does not advance the pointer
    done = xferCycle && (st_reg.dirRead ? (iorEnd && st_reg.popped) : (hostPush && fifoInReady));

    unique case (st_reg.xfer)
      XIDLE: begin
        if (xferStart && !st_reg.locked) begin
          st_next.xfer     = XRUN;
          st_next.dirRead  = xferDirRead;
          st_next.xferDone = 1'b0;
        end
      end
      XRUN: begin
        if (done) begin
          st_next.hostPtr = st_reg.hostPtr + WORD_STEP;
          if (stopHit) begin
            if (st_reg.longCmd) begin
              st_next.xfer = XDRAIN;
            end else begin
              st_next.xfer     = XIDLE;
              st_next.xferDone = 1'b1;
            end
          end
        end
      end
      XDRAIN: begin
        if (!fifoOutValid && !st_reg.popped) begin
          st_next.xfer     = XECC;
          st_next.byteMode = 1'b1;
          st_next.eccLeft  = eccBytes(cfg.eccSelect);
        end
      end
      XECC: begin
        if (done) begin
          st_next.hostPtr = st_reg.hostPtr + BYTE_STEP;
          st_next.eccLeft = st_reg.eccLeft - 4'h1;
          if (st_reg.eccLeft == 4'h1) begin
            st_next.xfer     = XIDLE;
            st_next.byteMode = 1'b0;
            st_next.xferDone = 1'b1;
          end
        end
      end
    endcase

    // Stop pointer and transfer registers are closed while locked
    if (stopLoad && !st_reg.locked) begin
      st_next.stopPtr   = stopValue;
      st_next.stopArmed = 1'b1;
    end
    if (unlockWrite) begin
      st_next.locked = 1'b0;
    end

    // Every controller captures the command, only the selected one acts unless it is the diagnostic command
    if (cmdWrite) begin
      st_next.cmdByte    = h.wrData[7:0];
      // A completion in the same cycle wins over the clear
      st_next.xferDone   = st_next.xferDone && !st_reg.xferDone;
      st_next.execCmd    = selected || diagCmd;
      st_next.reportBoth = diagCmd && cfg.masterSlaveEn && !cfg.slaveSelect;
      st_next.longCmd    = h.wrData[CMD_LONG_BIT];
    end
    if (autoCmd) begin
      st_next.xfer      = XRUN;
      st_next.dirRead   = 1'b0;
      st_next.byteMode  = 1'b0;
      st_next.stopPtr   = STOP_PTR_INIT;
      st_next.stopArmed = !cfg.stopPtrDisable;
      st_next.locked    = 1'b1;
      st_next.mcuIrq    = cfg.mcuIrqEn;
    end

    // Programmed count first, then automatic waits while not ready
    if (strobeStart) begin
      wl = cfg.waitCount;
    end else if (wl != 2'h0) begin
      wl = wl - 2'h1;
    end
    st_next.waitLeft = wl;
    st_next.waitOe   = pioCycle && ((wl != 2'h0) ||
                       (cfg.autoWaitEn && h.dataSel && xferActive && !devReady));

    // Demand mode keeps requesting through acknowledge, single mode releases
    st_next.dreq    = cfg.demandModeEn ? okReq : (okReq && h.dack_n);
    st_next.hostIrq = hostIrqReq && !(xferActive && dmaOk);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign mcuIrq             = st_reg.mcuIrq;
  assign formatterConnected = !st_reg.locked;
  assign mcuRegWriteAllow   = !st_reg.locked;
  assign mcuBufAccessAllow  = !st_reg.locked;
  assign hostDreq           = st_reg.dreq;
  assign hostIochrdyOe      = st_reg.waitOe;
  assign hostRdData         = st_reg.rdData;
  assign hostDataOe         = st_reg.dataOe;
  assign hostIrq            = st_reg.hostIrq;
  assign hostBufferPointer  = st_reg.hostPtr;
  assign stopPointer        = st_reg.stopPtr;
  assign xferDone           = st_reg.xferDone;
  assign hostByteMode       = st_reg.byteMode;
  assign cmdByte            = st_reg.cmdByte;
  assign execCommand        = st_reg.execCmd;
  assign reportBoth         = st_reg.reportBoth;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  irq_dma_quiet_a: assert property (hostDreq |-> !hostIrq)
    else $error("host interrupt raised during DMA");
  pio_no_dma_a: assert property (cfg.atMode && cfg.pioSelect |=> !hostDreq)
    else $error("DMA request while PIO selected");
  gate_blocks_dma_a: assert property (cfg.atMode && cfg.hostDmaGateEnable &&
                                      !cfg.fixedDiskDmaBit |=> !hostDreq)
    else $error("gated DMA requested without fixed-disk bit");
  single_release_a: assert property (!cfg.demandModeEn && !h.dack_n |=> !hostDreq)
    else $error("single mode request held through acknowledge");
  demand_hold_a: assert property (cfg.demandModeEn && okReq |=> hostDreq)
    else $error("demand request dropped while ready");
  wait_not_dma_a: assert property (!h.dack_n |=> !hostIochrdyOe)
    else $error("wait state during DMA");
  wait_prog_a: assert property (strobeStart && pioCycle && cfg.waitCount != 2'h0
                                |=> hostIochrdyOe)
    else $error("programmed wait state missing");
  auto_lock_a: assert property (autoCmd |=> stopPointer == STOP_PTR_INIT &&
                                !mcuRegWriteAllow && !formatterConnected && !mcuBufAccessAllow)
    else $error("auto-start did not load stop pointer or lock");
  mcu_irq_gate_a: assert property (mcuIrq |-> $past(autoCmd) && $past(cfg.mcuIrqEn))
    else $error("microcontroller interrupt without enabled auto-start");
  unlock_open_a: assert property (unlockWrite && !autoCmd |=> mcuRegWriteAllow &&
                                  formatterConnected)
    else $error("unlock did not restore access");
  long_past_stop_a: assert property (st_reg.xfer == XRUN && st_reg.longCmd && stopHit &&
                                     xferCycle && hostPush && fifoInReady && !cmdWrite
                                     |=> st_reg.xfer == XDRAIN)
    else $error("long command stopped at stop pointer");
  ecc_len_a: assert property ($rose(hostByteMode) && !$past(autoCmd)
                              |-> st_reg.eccLeft == eccBytes($past(cfg.eccSelect)))
    else $error("ECC byte count wrong");
  exec_select_a: assert property (execCommand |-> $past(cmdWrite && (selected || diagCmd)))
    else $error("command executed by unselected controller");
endmodule // pchtp_port

// [logic/pchtp_pkg.sv]
package pchtp_pkg;

  localparam int          DATA_W        = 16;
  localparam int          FIFO_DEPTH    = 4;
  localparam logic [15:0] STOP_PTR_INIT = 16'h01ff;
  localparam logic [15:0] WORD_STEP     = 16'h0002;
  localparam logic [15:0] BYTE_STEP     = 16'h0001;
  localparam logic [7:0]  CMD_WRITE_BUF = 8'he8;
  localparam logic [3:0]  CMD_FORMAT_HI = 4'h5;
  localparam logic [3:0]  CMD_WRITE_HI  = 4'h3;
  localparam int          CMD_LONG_BIT  = 1;
  localparam logic [7:0]  CMD_DIAG      = 8'h90;
  localparam logic [1:0]  ECC_SEL_32    = 2'h0;
  localparam logic [1:0]  ECC_SEL_56    = 2'h1;
  localparam logic [3:0]  ECC_BYTES_32  = 4'h4;
  localparam logic [3:0]  ECC_BYTES_56  = 4'h7;
  localparam logic [3:0]  ECC_BYTES_88  = 4'hb;

  typedef enum logic [1:0] {XIDLE, XRUN, XDRAIN, XECC} pchtp_xfer_t;

  typedef struct packed {
    logic       atMode;
    logic       demandModeEn;
    logic       pioSelect;
    logic       hostDmaGateEnable;
    logic       xtDmaEnable;
    logic       fixedDiskDmaBit;
    logic [1:0] waitCount;
    logic       autoWaitEn;
    logic       stopPtrDisable;
    logic       masterSlaveEn;
    logic       slaveSelect;
    logic [1:0] eccSelect;
    logic       mcuIrqEn;
  } pchtp_cfg_t;

  typedef struct packed {
    logic        ior_n;
    logic        iow_n;
    logic        dack_n;
    logic        dataSel;
    logic        cmdSel;
    logic        ioSel;
    logic        atDriveSel;
    logic        xtSlaveBit;
    logic [15:0] wrData;
  } pchtp_host_in_t;

  localparam pchtp_host_in_t HOST_IDLE = '{ior_n: 1'b1, iow_n: 1'b1, dack_n: 1'b1, default: '0};

  function automatic logic [3:0] eccBytes(input logic [1:0] sel);
    return (sel == ECC_SEL_32) ? ECC_BYTES_32 : (sel == ECC_SEL_56) ? ECC_BYTES_56 : ECC_BYTES_88;
  endfunction

  function automatic logic isAutoCmd(input logic [7:0] cmd);
    return (cmd[7:4] == CMD_FORMAT_HI) || (cmd[7:4] == CMD_WRITE_HI) || (cmd == CMD_WRITE_BUF);
  endfunction

endpackage

// [dv/pchtp_host_bfm.sv]
`timescale 1ns/1ps

module pchtp_host_bfm (
  // Clock and port status
  input  wire logic                 core_clk,
  input  wire logic                 hostDreq,
  input  wire logic                 hostIochrdyOe,
  // Host pins
  output pchtp_pkg::pchtp_host_in_t hostIn
);
  import pchtp_pkg::*;

  logic        dmaOn = 1'b0;
  // Set by the bench to strobe reads instead of writes
  logic        rdMode = 1'b0;
  logic        dropped;
  logic [15:0] word;
  logic [15:0] sentQ[$];
  int          dmaCount = 0;
  int          ackDrops = 0;
  int          dmaWaits = 0;

  initial hostIn = HOST_IDLE;

  // Strobe held while IOCHRDY is pulled low; bounded so a stuck port cannot hang
  task automatic io_write(input logic isCmd, input logic [15:0] d, output int waits);
    int n;
    n = 0;
    waits = 0;
    @(posedge core_clk);
    hostIn.cmdSel <= isCmd;
    hostIn.dataSel <= !isCmd;
    hostIn.ioSel <= 1'b1;
    hostIn.wrData <= d;
    if (rdMode) hostIn.ior_n <= 1'b0;
    else hostIn.iow_n <= 1'b0;
    do begin
      @(posedge core_clk);
      n++;
      if (hostIochrdyOe === 1'b1) waits++;
    end while ((n < 4 || hostIochrdyOe === 1'b1) && n < 300);
    hostIn.iow_n <= 1'b1;
    hostIn.ior_n <= 1'b1;
    if (!isCmd && !rdMode) sentQ.push_back(d);
    repeat (4) @(posedge core_clk);
    // Released data lines must not keep showing the last word
    hostIn.wrData <= ~d;
    hostIn.cmdSel <= 1'b0;
    hostIn.dataSel <= 1'b0;
    hostIn.ioSel <= 1'b0;
    #1;
  endtask

  task automatic set_drive(input logic d);
    @(posedge core_clk);
    hostIn.atDriveSel <= d;
    hostIn.xtSlaveBit <= d;
  endtask

  task automatic ack_hold(input int n);
    repeat (n) begin
      @(posedge core_clk);
      if (hostDreq !== 1'b1) dropped = 1'b1;
      if (hostIochrdyOe === 1'b1) dmaWaits++;
    end
  endtask

  // DMA channel: one word per grant, acknowledge held for 10 cycles whether or not the request stands
  always begin
    @(posedge core_clk);
    if (dmaOn && hostDreq === 1'b1) begin
      dropped = 1'b0;
      word = 16'($urandom);
      hostIn.dack_n <= 1'b0;
      hostIn.wrData <= word;
      ack_hold(2);
      hostIn.iow_n <= 1'b0;
      ack_hold(4);
      hostIn.iow_n <= 1'b1;
      sentQ.push_back(word);
      ack_hold(3);
      dmaCount++;
      if (dropped) ackDrops++;
    end else begin
      hostIn.dack_n <= 1'b1;
      if (dmaOn) hostIn.wrData <= ~hostIn.wrData;
    end
  end
endmodule // pchtp_host_bfm

// [dv/tb.sv]
`timescale 1ns/1ps

module tb;
  import pchtp_pkg::*;

  logic           core_clk = 1'b0;
  logic           rstn = 1'b0;
  pchtp_cfg_t     cfg = '0;
  pchtp_cfg_t     c;
  pchtp_host_in_t hostIn;
  logic           stopLoad = 1'b0, unlockWrite = 1'b0, hostIrqReq = 1'b0, bufWrReady = 1'b1;
  logic           xferStart = 1'b0, xferDirRead = 1'b0, hostDataOe, bufRdReady;
  logic [15:0]    stopValue = 16'h0000;
  logic [15:0]    rdWord = 16'h0000, hostRdData, hostBufferPointer;
  logic           mcuIrq, formatterConnected, mcuRegWriteAllow, mcuBufAccessAllow;
  logic           hostDreq, hostIochrdyOe, hostIrq, xferDone, hostByteMode, ok, isAuto;
  logic           execCommand, reportBoth, bufWrValid;
  logic [15:0]    stopPointer, bufWrData;
  logic [7:0]     cmdByte;
  logic [2:0]     allow;
  logic [15:0]    gotQ[$];
  logic [7:0]     codes[8] = '{8'h50, 8'h5f, 8'he8, 8'h30, 8'h3f, 8'h20, 8'h90, 8'he9};
  int             n_fail = 0;
  int             num_checks = 0;
  int             nIrq, nExec, nOe, w, nw, nb;

  assign allow = {formatterConnected, mcuRegWriteAllow, mcuBufAccessAllow};

  pchtp_port u_pchtp_port (
    .core_clk(core_clk), .rstn(rstn), .cfg(cfg), .xferStart(xferStart),
    .xferDirRead(xferDirRead),
    .stopLoad(stopLoad), .stopValue(stopValue), .unlockWrite(unlockWrite),
    .hostIrqReq(hostIrqReq), .mcuIrq(mcuIrq), .formatterConnected(formatterConnected),
    .mcuRegWriteAllow(mcuRegWriteAllow), .mcuBufAccessAllow(mcuBufAccessAllow),
    .hostIn(hostIn), .hostDreq(hostDreq), .hostIochrdyOe(hostIochrdyOe),
    .hostRdData(hostRdData), .hostDataOe(hostDataOe), .hostIrq(hostIrq),
    .hostBufferPointer(hostBufferPointer), .stopPointer(stopPointer),
    .xferDone(xferDone), .hostByteMode(hostByteMode), .cmdByte(cmdByte),
    .execCommand(execCommand), .reportBoth(reportBoth), .bufWrValid(bufWrValid),
    .bufWrData(bufWrData), .bufWrReady(bufWrReady), .bufRdValid(1'b1),
    .bufRdData(rdWord), .bufRdReady(bufRdReady)
  );

  pchtp_host_bfm host (
    .core_clk(core_clk), .hostDreq(hostDreq), .hostIochrdyOe(hostIochrdyOe), .hostIn(hostIn)
  );

  always @(posedge core_clk) begin
    if (mcuIrq === 1'b1) nIrq++;
    if (execCommand === 1'b1) nExec++;
    if (hostDataOe === 1'b1) nOe++;
    // Buffer model hands out counting words
    if (bufRdReady === 1'b1) rdWord <= rdWord + 16'h0001;
    if (bufWrValid === 1'b1 && bufWrReady === 1'b1) gotQ.push_back(bufWrData);
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic pchtp_cfg_t base(input logic at, input logic pio);
    base = '0;
    base.atMode = at;
    base.pioSelect = pio;
  endfunction

  task automatic do_reset(input pchtp_cfg_t cc);
    @(posedge core_clk);
    rstn <= 1'b0;
    cfg <= cc;
    hostIrqReq <= 1'b0;
    bufWrReady <= 1'b1;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1;
    gotQ.delete();
    host.sentQ.delete();
    host.dmaCount = 0;
    host.ackDrops = 0;
    host.dmaWaits = 0;
    nIrq = 0;
    nExec = 0;
    nOe = 0;
  endtask

  task automatic mcu_pulse(input logic isStop, input logic [15:0] v);
    @(posedge core_clk);
    stopLoad <= isStop;
    unlockWrite <= !isStop;
    stopValue <= v;
    @(posedge core_clk);
    stopLoad <= 1'b0;
    unlockWrite <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
  endtask

  task automatic send_cmd(input logic [7:0] cd);
    host.io_write(1'b1, {8'h00, cd}, w);
  endtask

  task automatic cmp_stream();
    check("word count", gotQ.size(), host.sentQ.size());
    for (int i = 0; i < host.sentQ.size() && i < gotQ.size(); i++)
      check("buffer word", gotQ[i], host.sentQ[i]);
  endtask

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  // Whole run needs about 2100 cycles
  initial begin
    #80000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h1d9d01d8));
    do_reset(base(1'b1, 1'b1));
    check("reset state", {hostDreq, hostIochrdyOe, hostIrq, xferDone, mcuIrq, allow}, 8'h07);
    foreach (codes[i]) begin
      c = base(1'b1, 1'b1);
      c.mcuIrqEn = 1'($urandom);
      do_reset(c);
      isAuto = codes[i][7:4] == 4'h5 || codes[i][7:4] == 4'h3 || codes[i] == 8'he8;
      send_cmd(codes[i]);
      check("cmdByte", cmdByte, codes[i]);
      check("exec", nExec, 1);
      check("mcuIrq", nIrq, isAuto && c.mcuIrqEn);
      check("stop", stopPointer, isAuto ? 16'h01ff : 16'h0000);
      check("allow", allow, isAuto ? 3'b000 : 3'b111);
      mcu_pulse(1'b1, 16'h0123);
      check("stop", stopPointer, isAuto ? 16'h01ff : 16'h0123);
      mcu_pulse(1'b0, 16'h0000);
      check("allow", allow, 3'b111);
    end
    $display("test commands done");
    for (int i = 0; i < 32; i++) begin
      c = base(i[0], i[1]);
      c.hostDmaGateEnable = i[2];
      c.fixedDiskDmaBit = i[3];
      c.xtDmaEnable = i[4];
      c.demandModeEn = 1'($urandom);
      do_reset(c);
      @(posedge core_clk);
      hostIrqReq <= 1'b1;
      send_cmd(8'h30);
      repeat (6) @(posedge core_clk);
      #1;
      ok = c.atMode ? !c.pioSelect && (!c.hostDmaGateEnable || c.fixedDiskDmaBit) : c.xtDmaEnable;
      check("dreq", hostDreq, ok);
      check("hostIrq", hostIrq, !ok);
    end
    $display("test dma table done");
    for (int m = 0; m < 2; m++) begin
      c = base(1'b1, 1'b0);
      c.demandModeEn = m[0];
      c.waitCount = 2'h3;
      do_reset(c);
      send_cmd(8'h30);
      @(posedge core_clk);
      host.dmaOn <= 1'b1;
      for (int k = 0; k < 400 && host.dmaCount < 6; k++) @(posedge core_clk);
      host.dmaOn <= 1'b0;
      repeat (20) @(posedge core_clk);
      check("dma words", host.dmaCount >= 6, 1);
      check("dreq drops", host.ackDrops, m ? 0 : host.dmaCount);
      check("dma waits", host.dmaWaits, 0);
      cmp_stream();
    end
    $display("test dma runs done");
    do_reset(base(1'b1, 1'b1));
    send_cmd(8'h30);
    for (int k = 0; k < 4; k++) begin
      @(posedge core_clk);
      cfg.waitCount <= k[1:0];
      host.io_write(1'b0, 16'($urandom), w);
      check("waits", w != 0, k != 0);
    end
    @(posedge core_clk);
    cfg.autoWaitEn <= 1'b1;
    bufWrReady <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      host.io_write(1'b0, 16'($urandom), w);
      check("short waits", w < 8, 1);
    end
    // Buffer stalls until the fifth word has been held off
    fork
      begin
        repeat (40) @(posedge core_clk);
        bufWrReady <= 1'b1;
      end
    join_none
    host.io_write(1'b0, 16'($urandom), w);
    check("full waits", w > 30, 1);
    repeat (10) @(posedge core_clk);
    cmp_stream();
    $display("test wait states done");
    for (int e = 0; e < 4; e++) begin
      c = base(1'b1, 1'b1);
      c.eccSelect = e[1:0];
      c.stopPtrDisable = e[0];
      do_reset(c);
      send_cmd(e == 3 ? 8'h30 : 8'h32);
      mcu_pulse(1'b0, 16'h0000);
      mcu_pulse(1'b1, 16'h0006);
      nw = 0;
      while (hostByteMode !== 1'b1 && xferDone !== 1'b1 && nw < 10) begin
        host.io_write(1'b0, 16'($urandom), w);
        nw++;
        repeat (4) @(posedge core_clk);
        #1;
      end
      check("words", nw, 4);
      nb = 0;
      while (xferDone !== 1'b1 && nb < 20) begin
        host.io_write(1'b0, 16'($urandom), w);
        nb++;
      end
      check("ecc bytes", nb, e == 0 ? 4 : e == 1 ? 7 : e == 2 ? 11 : 0);
      check("pointer", hostBufferPointer, 8 + (e == 0 ? 4 : e == 1 ? 7 : e == 2 ? 11 : 0));
    end
    $display("test long commands done");
    for (int i = 0; i < 16; i++) begin
      c = base(i[0], 1'b1);
      c.masterSlaveEn = 1'b1;
      c.slaveSelect = i[1];
      do_reset(c);
      host.set_drive(i[2]);
      send_cmd(i[3] ? 8'h90 : 8'h30);
      ok = i[1] == i[2];
      check("exec", nExec, ok || i[3]);
      check("allow", allow, (ok && !i[3]) ? 3'b000 : 3'b111);
      check("cmdByte", cmdByte, i[3] ? 8'h90 : 8'h30);
      check("reportBoth", reportBoth, i[3] && !i[1]);
    end
    $display("test master slave done");
    do_reset(base(1'b1, 1'b1));
    @(posedge core_clk);
    xferStart <= 1'b1;
    xferDirRead <= 1'b1;
    @(posedge core_clk);
    xferStart <= 1'b0;
    host.rdMode = 1'b1;
    for (int k = 0; k < 3; k++) begin
      host.io_write(1'b0, 16'($urandom), w);
      check("read word", hostRdData, k);
      check("read waits", w, 0);
    end
    host.rdMode = 1'b0;
    check("read enable", nOe, 12);
    check("read pointer", hostBufferPointer, 16'h0006);
    $display("test host read done");
    tally_and_finish();
  end
endmodule // tb
